// File: rtl/nsp_cfg.svh
`ifndef NSP_CFG_SVH
`define NSP_CFG_SVH
// base unit width, byte width, lane count and vector length
`define NSP_UNIT_W      12
`define NSP_BYTE_W      8
`define NSP_LANES       4
`define NSP_VEC_LEN     4
// framing modes
`define NSP_FRAME_NONE  2'h0
`define NSP_FRAME_UNIT  2'h1
`define NSP_FRAME_VEC   2'h2
`endif

// File: rtl/nsp_pkg.sv
package nsp_pkg;
   typedef enum logic [1:0] {
      NSP_FRAME_NONE_E = 2'h0,
      NSP_FRAME_UNIT_E = 2'h1,
      NSP_FRAME_VEC_E  = 2'h2
   } nsp_frame_e;
endpackage

// File: rtl/nsp_stream_if.sv
`timescale 1ns/10ps
interface nsp_stream_if #(
   parameter int DW = 64
) (
   input wire logic core_clk_i
);
   logic            tvalid;
   logic            tready;
   logic [DW-1:0]   tdata;
   logic [DW/8-1:0] tkeep;
   logic            tlast;

   modport master (output tvalid, output tdata, output tkeep, output tlast, input tready);
   modport slave  (input tvalid, input tdata, input tkeep, input tlast, output tready);
endinterface

// File: rtl/nsp_unit_ext.sv
`timescale 1ns/10ps
// widens one base unit to its byte-rounded field
module nsp_unit_ext #(
   parameter int N = 12,
   parameter int P = ((N + 7) / 8) * 8
) (
   input  wire logic [N-1:0] unit_i,
   input  wire logic         signed_i,
   output logic      [P-1:0] field_o
);
   logic pad_bit;
   assign pad_bit = signed_i & unit_i[N-1];
   assign field_o = {{(P-N){pad_bit}}, unit_i}; // R8 R9
endmodule

// File: rtl/nsp_packer.sv
`timescale 1ns/10ps
`include "nsp_cfg.svh"
// Notes on behaviour
// R1: valid always present, ready included
// R2: null bytes only for packet remainder
// R3: remainder marked by keep, no strobe
// R4: no stream id or destination signals
// R5: unit rounded up to whole bytes
// R6: data width is multiple of eight
// R7: receiver ignores padding bits
// R8: unsigned padding driven as zeros
// R9: signed padding copies the sign bit
// R10: complex is real unit then imaginary
// R11: one unit width per stream
// R12: fill lanes first, then next beats
// R13: sub-fields joined before byte padding; here each unit, real or imaginary, is padded to P bits on its own
// R14: fixed or floating point both allowed
// R15: unpacketized scalars keep last low
// R16: unit-length vectors assert last always
// R17: cleared keep only on last beat
// R18: receiver reads keep only on last
// R19: never a beat with all keep clear
// R20: transfer on valid and ready; hold
// R21: first unit in lowest lanes
module nsp_packer
   import nsp_pkg::*;
#(
   parameter int N       = `NSP_UNIT_W,
   parameter int LANES   = `NSP_LANES,
   parameter int VEC_LEN = `NSP_VEC_LEN,
   parameter int P       = ((N + 7) / 8) * 8, // R5 R13
   parameter int DW      = LANES * P          // R6 R11
) (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rstn_i,
   // configuration
   input  wire logic        signed_i,
   input  wire logic        complex_i,
   input  wire nsp_frame_e  frame_i,
   // application side: one base unit per request
   input  wire logic [N-1:0] unit_i,
   input  wire logic        unit_valid_i,
   output logic             unit_ready_o,
   // stream master
   nsp_stream_if.master     m
);
   localparam int CW  = $clog2(LANES + 1);
   localparam int VW  = $clog2(2 * VEC_LEN + 1);
   localparam int BPU = P / 8;

   // =================================================
   // declarations
   // =================================================
   wire logic [DW-1:0]   data_w;
   wire logic [DW/8-1:0] keep_w;
   logic [P-1:0]         field;
   logic [CW-1:0]        fill_ff;
   logic [CW-1:0]        nxt_fill;
   logic [VW-1:0]        cnt_ff;
   logic [VW-1:0]        nxt_cnt;
   logic                 valid_ff;
   logic                 nxt_valid;
   logic                 ready_ff;
   logic                 last_ff;
   logic [DW/8-1:0]      keep_ff;
   logic                 take;
   logic                 beat_done;
   logic                 close_beat;
   logic                 framed;
   logic [VW-1:0]        units_in_pkt;
   logic                 pkt_end;
   logic                 beat_full;

   nsp_unit_ext #(.N(N), .P(P)) u_ext (
      .unit_i   (unit_i),
      .signed_i (signed_i),
      .field_o  (field)
   );

   // =================================================
   // handshake
   // =================================================
   // a unit is accepted only while no beat is waiting, so data never moves under valid
   assign take         = unit_valid_i & ready_ff;           // R20
   assign beat_done    = valid_ff & m.tready;               // R1 R20
   assign framed       = (frame_i != NSP_FRAME_NONE_E);
   // complex values take two units, real part first
   assign units_in_pkt = (frame_i == NSP_FRAME_UNIT_E) ? (complex_i ? VW'(2) : VW'(1))
                       : (complex_i ? VW'(2 * VEC_LEN) : VW'(VEC_LEN)); // R10 R16
   assign pkt_end      = framed && (cnt_ff + VW'(1) == units_in_pkt);
   assign beat_full    = (fill_ff + CW'(1) == CW'(LANES));
   assign close_beat   = take & (beat_full | pkt_end);

   // =================================================
   // lane and packet counters
   // =================================================
   always_comb begin
      nxt_fill = fill_ff;
      nxt_cnt  = cnt_ff;
      if (take) begin
         nxt_fill = close_beat ? '0 : fill_ff + CW'(1);
         // unframed streams never count, so a mode switch starts clean
         nxt_cnt  = (pkt_end || !framed) ? '0 : cnt_ff + VW'(1);
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fill_ff <= '0;
      end else begin
         fill_ff <= nxt_fill;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // =================================================
   // per-lane storage and keep
   // =================================================
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [P-1:0] lane_ff;
      // first unit lowest lanes, later ones higher
      always_ff @(posedge core_clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            lane_ff <= '0;
         end else if (take && (fill_ff == CW'(g))) begin
            lane_ff <= field;                               // R12 R21 R7
         end
      end
      assign data_w[g*P +: P] = lane_ff;
      // stale upper lanes of a remainder beat are masked, never cleared
      assign keep_w[g*BPU +: BPU] = {BPU{(CW'(g) <= fill_ff)}}; // R2 R3 R17 R19
   end

   // =================================================
   // beat output
   // =================================================
   always_comb begin
      nxt_valid = valid_ff;
      if (close_beat) begin
         nxt_valid = 1'b1;
      end else if (beat_done) begin
         nxt_valid = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         valid_ff <= 1'b0;
      end else begin
         valid_ff <= nxt_valid;
      end
   end

   // registered copy of not-valid, so the ready output comes from a flop
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ready_ff <= 1'b1;
      end else begin
         ready_ff <= ~nxt_valid;                            // R20
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         last_ff <= 1'b0;
         keep_ff <= '0;
      end else if (close_beat) begin
         last_ff <= pkt_end;                                // R15 R16
         // partial beats only at packet end, never empty
         keep_ff <= keep_w;                                 // R2 R17 R19
      end
   end

   // no strobe, id or destination: endpoint only
   assign unit_ready_o = ready_ff;
   assign m.tvalid     = valid_ff;                          // R4
   assign m.tdata      = data_w;                            // R14
   assign m.tkeep      = keep_ff;
   assign m.tlast      = last_ff;
endmodule

// File: rtl/nsp_unpacker.sv
`timescale 1ns/10ps
`include "nsp_cfg.svh"
module nsp_unpacker
   import nsp_pkg::*;
#(
   parameter int N     = `NSP_UNIT_W,
   parameter int LANES = `NSP_LANES,
   parameter int P     = ((N + 7) / 8) * 8,
   parameter int DW    = LANES * P
) (
   // clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         rstn_i,
   // stream slave
   nsp_stream_if.slave       s,
   // application side: one base unit per handshake
   output logic [N-1:0]      unit_o,
   output logic              unit_valid_o,
   output logic              unit_last_o,
   input  wire logic         unit_ready_i
);
   localparam int CW = $clog2(LANES + 1);

   logic [DW-1:0]   data_ff;
   logic [DW/8-1:0] keep_ff;
   logic            last_ff;
   logic            full_ff;
   logic [CW-1:0]   idx_ff;
   logic [CW-1:0]   cnt;
   logic            final_unit;

   // =================================================
   // beat capture
   // =================================================
   assign s.tready = ~full_ff;                              // R1 R20
   // keep only counts on the last beat
   always_comb begin
      cnt = CW'(LANES);
      if (last_ff) begin                                     // R18
         cnt = '0;
         for (int i = 0; i < LANES; i++) begin
            if (keep_ff[i*(P/8)]) cnt = CW'(i + 1);
         end
      end
   end
   assign final_unit   = (idx_ff + CW'(1) >= cnt);
   assign unit_valid_o = full_ff;
   assign unit_o       = data_ff[idx_ff*P +: N];            // R7 R12 R21
   assign unit_last_o  = full_ff & last_ff & final_unit;

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         full_ff <= 1'b0;
         idx_ff  <= '0;
         data_ff <= '0;
         keep_ff <= '0;
         last_ff <= 1'b0;
      end else if (s.tvalid && !full_ff) begin
         full_ff <= 1'b1;
         idx_ff  <= '0;
         data_ff <= s.tdata;
         keep_ff <= s.tkeep;
         last_ff <= s.tlast;
      end else if (full_ff && unit_ready_i) begin
         idx_ff  <= final_unit ? '0 : idx_ff + CW'(1);
         full_ff <= ~final_unit;
      end
   end
endmodule

// File: verif/nsp_stream_props.sv
`timescale 1ns/10ps
module nsp_stream_props #(
   parameter int N  = 12,
   parameter int P  = 16,
   parameter int DW = 64
) (
   input wire logic            core_clk_i,
   input wire logic            rstn_i,
   input wire logic            tvalid,
   input wire logic            tready,
   input wire logic [DW-1:0]   tdata,
   input wire logic [DW/8-1:0] tkeep,
   input wire logic            tlast
);
   // ==========
   // stream wire rules
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_stall;
      tvalid && !tready;
   endsequence
   sequence s_xfer;
      tvalid && tready;
   endsequence
   a_valid_hold: assert property (s_stall |=> tvalid)
      else $error("valid dropped");
   a_data_hold: assert property (s_stall |=> $stable(tdata))
      else $error("data moved");
   a_ctrl_hold: assert property (s_stall |=> $stable(tkeep) && $stable(tlast))
      else $error("keep or last moved");
   a_gap_beat: assert property (s_xfer |=> !tvalid)
      else $error("no idle cycle");
   a_keep_whole: assert property (tvalid |-> (tkeep & (tkeep + 1'b1)) == '0)
      else $error("leading null byte");
   a_keep_last: assert property (tvalid && !(&tkeep) |-> tlast)
      else $error("null byte without last");
   a_keep_some: assert property (tvalid |-> |tkeep)
      else $error("empty beat");
   // only lane 0 is judged: upper lanes may be null in a remainder beat
   a_pad_ext: assert property (tvalid |-> tdata[P-1:N] == '0 ||
      tdata[P-1:N] == {(P-N){tdata[N-1]}})
      else $error("bad padding");
endmodule

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
   import nsp_pkg::*;
   localparam int N = 12, L = 4, V = 4, P = 16, DW = 64;
   logic         core_clk_i, rstn_i, signed_i, complex_i;
   logic         unit_valid_i, unit_ready_o, unit_valid_o, unit_last_o, unit_ready_i;
   nsp_frame_e   frame_i;
   logic [N-1:0] unit_i, unit_o;
   logic [N-1:0] sent[$];
   int           n_errors = 0, total_checks = 0, bi = 0, nr = 0, pl, upb;
   nsp_stream_if #(.DW(DW)) lnk (.core_clk_i(core_clk_i));
   nsp_packer #(.N(N), .LANES(L), .VEC_LEN(V)) nsp_packer_inst (.core_clk_i(core_clk_i),
      .rstn_i(rstn_i), .signed_i(signed_i), .complex_i(complex_i), .frame_i(frame_i),
      .unit_i(unit_i), .unit_valid_i(unit_valid_i), .unit_ready_o(unit_ready_o), .m(lnk));
   nsp_unpacker #(.N(N), .LANES(L)) nsp_unpacker_inst (.core_clk_i(core_clk_i),
      .rstn_i(rstn_i), .s(lnk), .unit_o(unit_o), .unit_valid_o(unit_valid_o),
      .unit_last_o(unit_last_o), .unit_ready_i(unit_ready_i));
   nsp_stream_props #(.N(N), .P(P), .DW(DW)) nsp_stream_props_inst (.core_clk_i(core_clk_i),
      .rstn_i(rstn_i), .tvalid(lnk.tvalid), .tready(lnk.tready), .tdata(lnk.tdata),
      .tkeep(lnk.tkeep), .tlast(lnk.tlast));
   // ==========
   // checking
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [P-1:0] ext(input logic [N-1:0] u);
      return signed_i ? {{(P-N){u[N-1]}}, u} : {{(P-N){1'b0}}, u};
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // a complex scalar packet is two units, so it fills two lanes
   assign pl = ((frame_i == NSP_FRAME_VEC_E) ? V : 1) * (complex_i ? 2 : 1);
   assign upb = (frame_i == NSP_FRAME_NONE_E || pl > L) ? L : pl;
   always @(posedge core_clk_i) begin
      unit_ready_i <= 1'($urandom);
      if (unit_valid_i && unit_ready_o) sent.push_back(unit_i);
      if (lnk.tvalid && lnk.tready) begin
         for (int k = 0; k < upb; k++) check(lnk.tdata[k*P +: P], ext(sent[bi+k]));
         check(lnk.tkeep, 64'((1 << (upb * P / 8)) - 1));
         check(lnk.tlast, frame_i != NSP_FRAME_NONE_E && (bi + upb) % pl == 0);
         bi += upb;
      end
      if (unit_valid_o && unit_ready_i) begin
         check(unit_o, sent[nr]);
         check(unit_last_o, frame_i != NSP_FRAME_NONE_E && (nr + 1) % pl == 0);
         nr++;
      end
   end
   // ==========
   // stimulus
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         unit_valid_i <= 1'b1;
         unit_i <= (i == 0) ? 12'h800 : (i == 1) ? 12'h7ff : N'($urandom);
         do @(posedge core_clk_i); while (unit_ready_o !== 1'b1);
      end
      unit_valid_i <= 1'b0;
   endtask
   initial begin
      core_clk_i = 0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   initial begin
      #100us;
      n_errors++;
      stop_test();
   end
   initial begin
      {rstn_i, signed_i, complex_i, unit_valid_i, unit_i, unit_ready_i} = '0;
      frame_i = NSP_FRAME_NONE_E;
      void'($urandom(32'h2a392227));
      repeat (4) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      // 16 units fills whole beats and whole packets in every mode
      for (int c = 0; c < 12; c++) begin
         @(posedge core_clk_i);
         frame_i <= nsp_frame_e'(c % 3);
         signed_i <= c[2];
         complex_i <= c[3] | (c == 5);
         @(posedge core_clk_i);
         send(16);
         for (int t = 0; t < 400 && nr < sent.size(); t++) @(posedge core_clk_i);
         check(nr, sent.size());
      end
      stop_test();
   end
endmodule
